// ==== bench/scp_host_model.sv ====
// Purpose: host controller driving the serial port
// Assumes: eight system clocks per serial bit
// Notes:   serial clock idles low between frames
`timescale 1ns/100ps
`default_nettype none
module scp_host_model (
   input  wire logic i_clk,
   input  wire logic i_sdo,
   input  wire logic i_sdo_oe,
   output var  logic o_cs_n,
   output var  logic o_sclk,
   output var  logic o_sdi
);
   logic [31:0] rx_q;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_sdi  = 1'b0;
      rx_q   = 32'h0;
   end
   task automatic half();
      repeat (4) @(posedge i_clk);
   endtask
   task automatic open_f();
      o_cs_n <= 1'b0;
      half();
   endtask
   task automatic close_f();
      half();
      o_cs_n <= 1'b1;
      o_sdi  <= ~o_sdi;
      half();
   endtask
   task automatic shift(input int n, input logic [31:0] tx);
      for (int k = n - 1; k >= 0; k--) begin
         o_sdi  <= tx[k];
         half();
         o_sclk <= 1'b1;
         half();
         o_sclk <= 1'b0;
         rx_q   <= {rx_q[30:0], i_sdo_oe ? i_sdo : 1'bx};
      end
   endtask
   // fifteen fill bytes then end byte
   task automatic resync();
      repeat (15) shift(8, 32'hff);
      shift(8, 32'hfe);
   endtask
   // clock edges with no selection
   task automatic stray(input int n);
      repeat (n) begin
         o_sclk <= 1'b1;
         half();
         o_sclk <= 1'b0;
         half();
      end
   endtask
endmodule
`default_nettype wire

// ==== bench/scp_port_checker.sv ====
// Purpose: port-level assertions for the serial command port
// Assumes: watches top-level ports only, bound below
// Notes:   wake window counted in helper logic
`timescale 1ns/100ps
`default_nettype none
module scp_port_checker #(
   parameter int WAKE_CYC = 1000000
) (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_cs_n,
   input wire logic        i_ext_clk,
   input wire logic        o_sdo_oe,
   input wire logic [2:0]  o_calibration_code,
   input wire logic        o_cal_start,
   input wire logic        o_standby,
   input wire logic        o_sleep,
   input wire logic        o_osc_ready,
   input wire logic        o_filter_halt,
   input wire logic        o_guard_enable,
   input wire logic        o_latch_sel_cfg,
   input wire logic [31:0] o_cfg
);
   int wake_q;
   // ==========================================
   // cycles spent waking from sleep
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wake_q <= 0;
      end else if (o_sleep || o_osc_ready) begin
         wake_q <= 0;
      end else begin
         wake_q <= wake_q + 1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==========================================
   property p_oe_off; i_cs_n [*4] |-> !o_sdo_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
   property p_oe_on; !i_cs_n [*6] |-> o_sdo_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("sdo not driven while selected");
   property p_sleep;
      o_sleep |-> o_filter_halt && !o_standby && (o_osc_ready == i_ext_clk);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
   property p_standby; $rose(o_standby) |-> o_cfg[30] && !o_cfg[31] && o_filter_halt; endproperty
   a_standby: assert property (p_standby) else $error("standby without its bits");
   property p_wake_max; wake_q <= WAKE_CYC + 2; endproperty
   a_wake_max: assert property (p_wake_max) else $error("wake delay too long");
   property p_wake_min; $rose(o_osc_ready) && !i_ext_clk |-> wake_q >= WAKE_CYC - 2; endproperty
   a_wake_min: assert property (p_wake_min) else $error("wake delay too short");
   property p_guard; o_guard_enable |-> !o_latch_sel_cfg; endproperty
   a_guard: assert property (p_guard) else $error("latch select not masked");
   property p_rs_only; $rose(o_cfg[29]) |-> (o_cfg & 32'hefffffff) == 32'h20000000; endproperty
   a_rs_only: assert property (p_rs_only) else $error("reset write kept other bits");
   property p_rv; $rose(o_cfg[28]) |-> o_cfg[29] && o_cfg[27:0] == 28'h0; endproperty
   a_rv: assert property (p_rv) else $error("reset flag without reset");
   property p_cal; o_cal_start |-> ##[0:1] o_calibration_code inside {3'h1, 3'h2, 3'h5, 3'h6};
   endproperty
   a_cal: assert property (p_cal) else $error("calibration on reserved code");
endmodule
bind scp_port scp_port_checker #(.WAKE_CYC(WAKE_CYC)) u_chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_ext_clk(i_ext_clk),
   .o_sdo_oe(o_sdo_oe), .o_calibration_code(o_calibration_code), .o_cal_start(o_cal_start),
   .o_standby(o_standby), .o_sleep(o_sleep), .o_osc_ready(o_osc_ready),
   .o_filter_halt(o_filter_halt), .o_guard_enable(o_guard_enable),
   .o_latch_sel_cfg(o_latch_sel_cfg), .o_cfg(o_cfg)
);
`default_nettype wire

// ==== bench/scp_port_tb_top.sv ====
// Purpose: self-checking bench for the serial command port
// Assumes: host model provides serial framing
// Notes:   short wake count for simulation
`timescale 1ns/100ps
`default_nettype none
module scp_port_tb_top;
   logic        i_clk;
   logic        i_rst;
   logic        i_ext_clk;
   logic        i_data_ready;
   logic [31:0] i_conv_data;
   int          n_fail, num_checks, cyc, n_conv, n_cal;
   wire         cs_n, sclk, sdi, sdo, oe, flag, cstart, cont, calst;
   wire         stby, slp, osc, halt, grd, lsel;
   wire  [2:0]  ptr, ccode;
   wire  [1:0]  latch;
   wire  [31:0] cfg;
   scp_port #(.NUM_CAL(4), .WAKE_CYC(20)) u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_sdi(sdi),
      .i_ext_clk(i_ext_clk), .i_data_ready(i_data_ready), .i_conv_data(i_conv_data),
      .o_sdo(sdo), .o_sdo_oe(oe), .o_port_flag(flag), .o_conv_start(cstart),
      .o_continuous(cont), .o_setup_pointer(ptr), .o_calibration_code(ccode),
      .o_cal_start(calst), .o_standby(stby), .o_sleep(slp), .o_osc_ready(osc),
      .o_filter_halt(halt), .o_guard_enable(grd), .o_latch_sel_cfg(lsel),
      .o_cfg_latch(latch), .o_cfg(cfg)
   );
   scp_host_model u_host (
      .i_clk(i_clk), .i_sdo(sdo), .i_sdo_oe(oe), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi)
   );
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cstart === 1'b1) n_conv++;
      if (calst === 1'b1) n_cal++;
      if (cyc == 60000) begin
         n_fail++;
         $display("unexpected timeout at %0t: got %h expected %h", $time, cyc, 0);
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [31:0] exp);
      u_host.shift(32, 32'h0);
      @(posedge i_clk);
      chk(u_host.rx_q, exp);
   endtask
   task automatic cmd(input logic [7:0] c);
      u_host.open_f();
      u_host.shift(8, {24'h0, c});
      u_host.close_f();
   endtask
   task automatic wreg(input logic [7:0] c, input logic [31:0] w);
      u_host.open_f();
      u_host.shift(8, {24'h0, c});
      u_host.shift(32, w);
      u_host.close_f();
   endtask
   task automatic rreg(input logic [7:0] c, input logic [31:0] exp);
      u_host.open_f();
      u_host.shift(8, {24'h0, c});
      rd(exp);
      u_host.close_f();
   endtask
   // ==========================================
   task automatic t_defaults();
      rreg(8'h0a, 32'h01000000);
      rreg(8'h09, 32'h0);
      rreg(8'h0d, 32'h0);
      rreg(8'h0b, 32'h0);
      rreg(8'h08, 32'h00a5c3f1);
   endtask
   task automatic t_three_wire();
      u_host.open_f();
      u_host.shift(8, 32'h02);
      u_host.shift(32, 32'h80000000);
      u_host.shift(8, 32'h32);
      u_host.shift(32, 32'h5a5a0f0f);
      u_host.shift(8, 32'h0a);
      rd(32'h80000000);
      u_host.shift(8, 32'h3a);
      rd(32'h5a5a0f0f);
      u_host.close_f();
   endtask
   task automatic t_resync();
      u_host.open_f();
      u_host.shift(8, 32'hff);
      u_host.shift(8, 32'h02);
      u_host.shift(32, 32'h12345678);
      u_host.resync();
      u_host.close_f();
      rreg(8'h0a, 32'h80000000);
   endtask
   task automatic t_array();
      u_host.open_f();
      u_host.shift(8, 32'h45);
      for (int i = 0; i < 4; i++) u_host.shift(32, 32'h0a0b0c00 + i);
      u_host.close_f();
      rreg(8'h2d, 32'h0a0b0c02);
      u_host.open_f();
      u_host.shift(8, 32'h4d);
      for (int i = 0; i < 4; i++) rd(32'h0a0b0c00 + i);
      u_host.shift(8, 32'h0a);
      rd(32'h80000000);
      u_host.close_f();
   endtask
   task automatic t_stray();
      u_host.stray(12);
      chk({31'h0, oe}, 32'h0);
      rreg(8'h1d, 32'h0a0b0c01);
   endtask
   task automatic t_commands();
      for (int p = 0; p < 8; p++) begin
         cmd({2'b10, 3'(p), 3'h0} | {1'b0, p[0], 6'h0});
         chk({28'h0, cont, ptr}, {28'h0, p[0], 3'(p)});
      end
      chk(n_conv, 8);
      i_data_ready <= 1'b1;
      @(posedge i_clk);
      i_data_ready <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk({31'h0, flag}, 32'h1);
      cmd(8'h00);
      chk({30'h0, flag, cont}, 32'h1);
      for (int c = 1; c < 8; c++) begin
         cmd({5'b10010, 3'(c)});
         if (c == 1 || c == 2 || c == 5 || c == 6) chk(ccode, c);
      end
      chk(n_cal, 4);
   endtask
   task automatic t_power();
      wreg(8'h03, 32'h40000000);
      chk({28'h0, stby, slp, halt, osc}, 32'hb);
      wreg(8'h03, 32'hc0000000);
      chk({28'h0, stby, slp, halt, osc}, 32'h6);
      wreg(8'h03, 32'h0);
      chk({31'h0, osc}, 32'h0);
      repeat (30) @(posedge i_clk);
      chk({31'h0, osc}, 32'h1);
      i_ext_clk <= 1'b1;
      wreg(8'h03, 32'hc0000000);
      wreg(8'h03, 32'h0);
      chk({31'h0, osc}, 32'h1);
      i_ext_clk <= 1'b0;
   endtask
   task automatic t_config();
      wreg(8'h03, 32'h0fffffff);
      chk({28'h0, grd, lsel, latch}, 32'hb);
      chk(cfg, 32'h0fd80000);
      rreg(8'h0b, 32'h0fd80000);
      wreg(8'h03, 32'h01c00000);
      chk({28'h0, grd, lsel, latch}, 32'h7);
   endtask
   task automatic t_sysreset();
      wreg(8'h03, 32'he4000000);
      rreg(8'h0b, 32'h30000000);
      rreg(8'h0b, 32'h20000000);
      u_host.open_f();
      u_host.shift(8, 32'h4a);
      for (int i = 0; i < 4; i++) rd(32'h01000000);
      u_host.close_f();
      rreg(8'h0d, 32'h0);
      wreg(8'h03, 32'h0);
      rreg(8'h0b, 32'h0);
   endtask
   initial begin
      i_rst        = 1'b1;
      i_ext_clk    = 1'b0;
      i_data_ready = 1'b0;
      i_conv_data  = 32'h00a5c3f1;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      t_defaults();
      t_three_wire();
      t_resync();
      t_array();
      t_stray();
      t_commands();
      t_power();
      t_config();
      t_sysreset();
      summarize();
   end
endmodule
`default_nettype wire

// ==== design/scp_port.v ====
// Purpose: serial command interpreter and configuration control
// Assumes: host serial clock far slower than i_clk; sampled after two flops
// Notes:   data in sampled on rising serial clock, data out changes on falling
//
// Notes on behaviour
// - three-bit setup pointer picks one of eight setups, zero is first.
// - calibration code 001,010,101,110 picks the four calibration kinds.
// - an all-ones byte is a resync fill byte, not a command.
// - byte fe ends resync, port then waits for a command byte.
// - null byte clears the port flag, continuous conversion keeps running.
// - port accessible only while chip select is low.
// - data output not driven while chip select is high.
// - serial clock edges ignored while chip select is high.
// - after a read command the device shifts out 32 register bits.
// - after a single read or write the port returns to command mode.
// - offset, gain, config, setup read/write; conversion data read only.
// - array commands move all gain, offset or setup registers at once.
// - array words go in ascending order, then command mode.
// - config moves as 32 bits, only twelve of them meaningful.
// - power-down enters power save; select bit picks standby or sleep.
// - standby keeps oscillator; sleep stops it, 20 ms restart delay.
// - writing one to the reset bit resets the internal logic.
// - reset-valid flag set by system reset, cleared on config read.
// - reset loads zeros, gains load 01000000.
// - host writes reset bit back to zero; port resumes command mode.
// - the resetting write sets only the reset bit.
// - guard bit turns latch output zero into the guard signal.
// - select 31, power-down 30, reset 29, reset-valid 28.
// - multi-convert bit zero single conversion, one continuous.
`timescale 1ns/100ps
`default_nettype none
`include "scp_regs.vh"
module scp_port #(
   parameter NUM_CAL   = 4,
   parameter WAKE_CYC  = `SCP_SLEEP_WAKE_CYC
) (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_cs_n,
   input  wire        i_sclk,
   input  wire        i_sdi,
   input  wire        i_ext_clk,
   input  wire        i_data_ready,
   input  wire [31:0] i_conv_data,
   output reg         o_sdo,
   output reg         o_sdo_oe,
   output reg         o_port_flag,
   output reg         o_conv_start,
   output reg         o_continuous,
   output reg  [2:0]  o_setup_pointer,
   output reg  [2:0]  o_calibration_code,
   output reg         o_cal_start,
   output reg         o_standby,
   output reg         o_sleep,
   output reg         o_osc_ready,
   output reg         o_filter_halt,
   output reg         o_guard_enable,
   output reg         o_latch_sel_cfg,
   output reg  [1:0]  o_cfg_latch,
   output reg  [31:0] o_cfg
);
   // ==========================================
   // input synchronisers and edges
   wire [2:0] pins_s;
   // select resets high so no false frame follows reset
   scp_sync #(.W(3), .INIT(3'h4)) u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async ({i_cs_n, i_sclk, i_sdi}),
      .o_sync  (pins_s)
   );
   wire cs_n_s = pins_s[2];
   wire sclk_s = pins_s[1];
   wire sdi_s  = pins_s[0];
   reg  sclk_q;
   wire rise = ~cs_n_s & sclk_s & ~sclk_q;
   wire fall = ~cs_n_s & ~sclk_s & sclk_q;

   localparam ST_CMD   = 2'd0;
   localparam ST_WR    = 2'd1;
   localparam ST_RD    = 2'd2;
   localparam NO_WORD  = 4'hf;

   reg [1:0]  state_q;
   reg [7:0]  cmd_q;
   reg [7:0]  shin_q;
   reg [31:0] word_q;
   reg [31:0] shout_q;
   reg [5:0]  bit_q;
   reg [2:0]  left_q;
   reg [3:0]  addr_q;
   reg        synced_q;
   reg        load_q;
   reg        load2_q;
   reg [31:0] cfg_q;
   reg        rv_q;
   reg        sys_rst_q;
   reg        we_q;
   reg [31:0] wdata_q;
   reg [31:0] wake_q;
   wire [31:0] rdata;

   // word address of a register class and channel
   function [3:0] word_addr;
      input [2:0] sel;
      input [1:0] ch;
      begin
         case (sel)
            `SCP_SEL_OFFSET: word_addr = {2'b00, ch};
            `SCP_SEL_GAIN:   word_addr = {2'b01, ch};
            `SCP_SEL_SETUP:  word_addr = {2'b10, ch};
            default:         word_addr = NO_WORD;
         endcase
      end
   endfunction

   // number of words in an array
   function [2:0] array_len;
      input [2:0] sel;
      begin
         array_len = (sel == `SCP_SEL_SETUP) ? 3'd4 : NUM_CAL[2:0];
      end
   endfunction

   scp_regfile u_regs (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_clr   (sys_rst_q),
      .i_we    (we_q),
      .i_waddr (addr_q),
      .i_wdata (wdata_q),
      .i_raddr (addr_q),
      .o_rdata (rdata)
   );

   wire [7:0] byte_in   = {shin_q[6:0], sdi_s};
   wire [31:0] word_in  = {word_q[30:0], sdi_s};
   wire [2:0] sel_in    = byte_in[2:0];

   // ==========================================
   // serial engine
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sclk_q       <= 1'b0;
         load2_q      <= 1'b0;
         state_q      <= ST_CMD;
         cmd_q        <= 8'h00;
         shin_q       <= 8'h00;
         word_q       <= 32'h00000000;
         shout_q      <= 32'h00000000;
         bit_q        <= 6'd0;
         left_q       <= 3'd0;
         addr_q       <= 4'h0;
         synced_q     <= 1'b1;
         load_q       <= 1'b0;
         cfg_q        <= `SCP_CFG_RESET;
         rv_q         <= 1'b0;
         sys_rst_q    <= 1'b0;
         we_q         <= 1'b0;
         wdata_q      <= 32'h00000000;
         o_port_flag  <= 1'b0;
         o_conv_start <= 1'b0;
         o_continuous <= 1'b0;
         o_setup_pointer    <= 3'd0;
         o_calibration_code <= 3'd0;
         o_cal_start  <= 1'b0;
         o_sdo        <= 1'b0;
         o_sdo_oe     <= 1'b0;
      end else begin
         sclk_q       <= sclk_s;
         // regfile output lags its address by one clock
         load2_q      <= load_q;
         we_q         <= 1'b0;
         sys_rst_q    <= 1'b0;
         o_conv_start <= 1'b0;
         o_cal_start  <= 1'b0;
         load_q       <= 1'b0;
         o_sdo_oe     <= ~cs_n_s;
         if (i_data_ready) begin
            o_port_flag <= 1'b1;
         end
         if (load2_q) begin
            // select zero reads the conversion word
            shout_q <= (cmd_q[2:0] == `SCP_SEL_CONFIG) ? {cfg_q[31:29], rv_q, cfg_q[27:0]}
                     : (cmd_q[2:0] == `SCP_SEL_DATA) ? i_conv_data
                     : rdata;
         end
         if (rise) begin
            case (state_q)
               ST_CMD: begin
                  shin_q <= byte_in;
                  bit_q  <= bit_q + 6'd1;
                  if (bit_q == 6'd7) begin
                     bit_q <= 6'd0;
                     cmd_q <= byte_in;
                     if (byte_in == `SCP_RESYNC_FILL_BYTE) begin
                        synced_q <= 1'b0;
                     end else if (!synced_q || byte_in == `SCP_RESYNC_END_BYTE) begin
                        if (byte_in == `SCP_RESYNC_END_BYTE) begin
                           synced_q <= 1'b1;
                        end
                     end else if (byte_in == `SCP_NULL_BYTE) begin
                        if (!i_data_ready) begin
                           o_port_flag <= 1'b0;
                        end
                     end else if (byte_in[`SCP_BIT_CMD]) begin
                        o_setup_pointer    <= byte_in[5:3];
                        o_calibration_code <= byte_in[2:0];
                        if (byte_in[2:0] == `SCP_CAL_NONE) begin
                           o_continuous <= byte_in[6];
                           o_conv_start <= 1'b1;
                        end else if (byte_in[2:0] == `SCP_CAL_SELF_OFS ||
                                     byte_in[2:0] == `SCP_CAL_SELF_GAIN ||
                                     byte_in[2:0] == `SCP_CAL_SYS_OFS ||
                                     byte_in[2:0] == `SCP_CAL_SYS_GAIN) begin
                           o_cal_start <= 1'b1;
                        end
                     end else if (word_addr(sel_in, 2'b00) != NO_WORD ||
                                  sel_in == `SCP_SEL_CONFIG ||
                                  (sel_in == `SCP_SEL_DATA && byte_in[`SCP_BIT_RD])) begin
                        addr_q <= byte_in[`SCP_BIT_ARRAY] ? word_addr(sel_in, 2'b00)
                                : word_addr(sel_in, byte_in[5:4]);
                        left_q <= byte_in[`SCP_BIT_ARRAY] && word_addr(sel_in, 2'b00) != NO_WORD
                                ? array_len(sel_in) : 3'd1;
                        state_q <= byte_in[`SCP_BIT_RD] ? ST_RD : ST_WR;
                        load_q <= byte_in[`SCP_BIT_RD];
                     end
                  end
               end
               ST_WR: begin
                  word_q <= word_in;
                  bit_q  <= bit_q + 6'd1;
                  if (bit_q == 6'd31) begin
                     bit_q <= 6'd0;
                     if (cmd_q[2:0] == `SCP_SEL_CONFIG) begin
                        if (word_in[`SCP_CFG_RST]) begin
                           cfg_q     <= 32'h00000000 | (32'h1 << `SCP_CFG_RST);
                           sys_rst_q <= 1'b1;
                           rv_q      <= 1'b1;
                        end else begin
                           cfg_q <= word_in & `SCP_CFG_USED_MASK & ~(32'h1 << `SCP_CFG_RV);
                        end
                     end else begin
                        we_q    <= 1'b1;
                        wdata_q <= word_in;
                     end
                     if (left_q == 3'd1) begin
                        state_q <= ST_CMD;
                     end
                     left_q <= left_q - 3'd1;
                  end
               end
               ST_RD: begin
                  bit_q <= bit_q + 6'd1;
                  if (bit_q == 6'd31) begin
                     bit_q <= 6'd0;
                     if (cmd_q[2:0] == `SCP_SEL_CONFIG) begin
                        rv_q <= 1'b0;
                     end
                     if (left_q == 3'd1) begin
                        state_q <= ST_CMD;
                     end else begin
                        addr_q <= addr_q + 4'h1;
                        load_q <= 1'b1;
                     end
                     left_q <= left_q - 3'd1;
                  end
               end
               default: begin
                  state_q <= ST_CMD;
               end
            endcase
         end
         if (we_q) begin
            addr_q <= addr_q + 4'h1;
         end
         if (state_q == ST_RD && fall) begin
            o_sdo   <= shout_q[31];
            shout_q <= {shout_q[30:0], 1'b0};
         end else if (state_q != ST_RD) begin
            o_sdo <= 1'b0;
         end
      end
   end

   // ==========================================
   // power save and configuration outputs
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wake_q          <= 32'h00000000;
         o_standby       <= 1'b0;
         o_sleep         <= 1'b0;
         o_osc_ready     <= 1'b1;
         o_filter_halt   <= 1'b0;
         o_guard_enable  <= 1'b0;
         o_latch_sel_cfg <= 1'b0;
         o_cfg_latch     <= 2'b00;
         o_cfg           <= `SCP_CFG_RESET;
      end else begin
         o_standby     <= cfg_q[`SCP_CFG_PDW] & ~cfg_q[`SCP_CFG_PSS];
         o_sleep       <= cfg_q[`SCP_CFG_PDW] & cfg_q[`SCP_CFG_PSS];
         o_filter_halt <= cfg_q[`SCP_CFG_PDW];
         if (cfg_q[`SCP_CFG_PDW] & cfg_q[`SCP_CFG_PSS]) begin
            wake_q      <= (i_ext_clk) ? 32'h00000000 : WAKE_CYC;
            o_osc_ready <= i_ext_clk;
         end else if (wake_q != 32'h00000000) begin
            wake_q      <= wake_q - 32'h1;
            o_osc_ready <= (wake_q == 32'h1);
         end else begin
            o_osc_ready <= 1'b1;
         end
         o_guard_enable  <= cfg_q[`SCP_CFG_GB];
         o_latch_sel_cfg <= cfg_q[`SCP_CFG_OLS] & ~cfg_q[`SCP_CFG_GB];
         o_cfg_latch     <= {cfg_q[`SCP_CFG_A1], cfg_q[`SCP_CFG_A0]};
         o_cfg           <= {cfg_q[31:29], rv_q, cfg_q[27:0]};
      end
   end
endmodule
`default_nettype wire

// ==== design/scp_regfile.v ====
// Purpose: storage for offset, gain and setup words
// Assumes: one write or one read per clock
// Notes:   read data come out of a register
`timescale 1ns/100ps
`default_nettype none
`include "scp_regs.vh"
module scp_regfile (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_clr,
   input  wire        i_we,
   input  wire [3:0]  i_waddr,
   input  wire [31:0] i_wdata,
   input  wire [3:0]  i_raddr,
   output reg  [31:0] o_rdata
);
   // ==========================================
   // word 0-3 offset, 4-7 gain, 8-11 setup
   reg [31:0] mem_q [0:11];
   genvar g;
   generate
      for (g = 0; g < 12; g = g + 1) begin : g_word
         always @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               mem_q[g] <= (g >= 4 && g < 8) ? `SCP_GAIN_RESET : `SCP_OFS_RESET;
            end else if (i_clr) begin
               mem_q[g] <= (g >= 4 && g < 8) ? `SCP_GAIN_RESET : `SCP_SETUP_RESET;
            end else if (i_we && i_waddr == g) begin
               mem_q[g] <= i_wdata;
            end
         end
      end
   endgenerate
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h00000000;
      end else if (i_raddr < 4'hc) begin
         o_rdata <= mem_q[i_raddr];
      end else begin
         o_rdata <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// ==== design/scp_sync.v ====
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to i_clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module scp_sync #(
   parameter         W    = 3,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input  wire         i_clk,
   input  wire         i_rst,
   input  wire [W-1:0] i_async,
   output reg  [W-1:0] o_sync
);
   reg [W-1:0] meta_q;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= INIT;
         o_sync <= INIT;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== pkg/scp_regs.vh ====
// Purpose: constants for the serial command port
// Assumes: included by the design files of this block
// Notes:   bit positions within the 32-bit configuration word
`ifndef SCP_REGS_VH
`define SCP_REGS_VH
// ==========================================
// command bytes
`define SCP_RESYNC_FILL_BYTE  8'hff
`define SCP_RESYNC_END_BYTE   8'hfe
`define SCP_NULL_BYTE         8'h00
`define SCP_BIT_CMD           7
`define SCP_BIT_ARRAY         6
`define SCP_BIT_RD            3
`define SCP_SEL_DATA          3'h0
`define SCP_SEL_OFFSET        3'h1
`define SCP_SEL_GAIN          3'h2
`define SCP_SEL_CONFIG        3'h3
`define SCP_SEL_SETUP         3'h5
`define SCP_CAL_NONE          3'h0
`define SCP_CAL_SELF_OFS      3'h1
`define SCP_CAL_SELF_GAIN     3'h2
`define SCP_CAL_SYS_OFS       3'h5
`define SCP_CAL_SYS_GAIN      3'h6
// ==========================================
// configuration word fields
`define SCP_CFG_PSS           31
`define SCP_CFG_PDW           30
`define SCP_CFG_RST           29
`define SCP_CFG_RV            28
`define SCP_CFG_IS            27
`define SCP_CFG_GB            26
`define SCP_CFG_VRS           25
`define SCP_CFG_A1            24
`define SCP_CFG_A0            23
`define SCP_CFG_OLS           22
`define SCP_CFG_OGS           20
`define SCP_CFG_FRS           19
`define SCP_CFG_USED_MASK     32'hffd80000
// ==========================================
// reset values
`define SCP_CFG_RESET         32'h00000000
`define SCP_OFS_RESET         32'h00000000
`define SCP_GAIN_RESET        32'h01000000
`define SCP_SETUP_RESET       32'h00000000
// ==========================================
// timing
`define SCP_CLK_MHZ           50
`define SCP_SLEEP_WAKE_MS     20
`define SCP_SLEEP_WAKE_CYC    (`SCP_SLEEP_WAKE_MS * `SCP_CLK_MHZ * 1000)
`define SCP_WORD_BITS         32
`endif
